// ---- inc/rlk_pkg.sv ----
// constants and types shared by the remote link status design
// assumes a single 250 MHz clock and an active low async reset
package rlk_pkg;

  // clock and line timing
  localparam int CLK_HZ = 250_000_000;
  localparam int DEF_BAUD = 57_600;
  localparam int DEF_BIT_CYC = CLK_HZ / DEF_BAUD;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  localparam int REPLY_TMO_US = 2000;
  localparam int REPLY_TMO_CYC = REPLY_TMO_US * CYC_PER_US;
  localparam int RCV_TMO_US = 20000;
  localparam int RCV_TMO_CYC = RCV_TMO_US * CYC_PER_US;

  // parity selection, odd after reset
  localparam logic [1:0] PAR_ODD = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h1;
  localparam logic [1:0] PAR_NONE = 2'h2;

  // driver status byte fields
  localparam int ST_XFER = 0;
  localparam int ST_RPAR = 3;
  localparam int ST_ROK = 4;
  localparam int ST_LINK = 5;
  localparam int ST_LOCAL = 6;
  localparam int ST_BEAT = 7;
  localparam logic [7:0] ST_RST = 8'h00;

  // receiver reply status byte fields
  localparam int RS_RPAR = 0;
  localparam int RS_ROK = 1;

  // serial framer states
  typedef enum logic [2:0] {
    RLK_IDLE = 3'b000,
    RLK_START = 3'b001,
    RLK_DATA = 3'b010,
    RLK_PAR = 3'b011,
    RLK_STOP = 3'b100
  } rlk_bit_t;

  // driver scan states
  typedef enum logic [1:0] {
    RLK_D_IDLE = 2'b00,
    RLK_D_TX0 = 2'b01,
    RLK_D_TX1 = 2'b10,
    RLK_D_WAIT = 2'b11
  } rlk_drv_t;

  // receiver frame states
  typedef enum logic [1:0] {
    RLK_R_RX0 = 2'b00,
    RLK_R_RX1 = 2'b01,
    RLK_R_TX0 = 2'b10,
    RLK_R_TX1 = 2'b11
  } rlk_rcv_t;

endpackage

// ---- rtl/rlk_serial.sv ----
// one serial byte framer: start, 8 data lsb first, optional parity, stop
// assumes bit_cyc of at least 2 and rx_line synchronous to clk
module rlk_serial (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // line settings
  input wire logic [15:0] bit_cyc,
  input wire logic [1:0] par_mode,
  // transmit side
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic tx_line,
  // receive side
  input wire logic rx_line,
  output logic [7:0] rx_data,
  output logic rx_valid,
  output logic rx_err
);

  rlk_pkg::rlk_bit_t tst_ff, nxt_tst, rst_ff, nxt_rst;
  logic [15:0] tcnt_ff, nxt_tcnt, rcnt_ff, nxt_rcnt;
  logic [2:0] tidx_ff, nxt_tidx, ridx_ff, nxt_ridx;
  logic [7:0] tsh_ff, nxt_tsh, rsh_ff, nxt_rsh, rdata_ff, nxt_rdata;
  logic tpar_ff, nxt_tpar, tline_ff, nxt_tline;
  logic rpe_ff, nxt_rpe, rval_ff, nxt_rval, rerr_ff, nxt_rerr;
  logic par_on, par_odd;

  assign par_on = (par_mode == rlk_pkg::PAR_ODD) ||
                  (par_mode == rlk_pkg::PAR_EVEN);
  assign par_odd = (par_mode == rlk_pkg::PAR_ODD);
  assign tx_ready = (tst_ff == rlk_pkg::RLK_IDLE);
  assign tx_line = tline_ff;
  assign rx_data = rdata_ff;
  assign rx_valid = rval_ff;
  assign rx_err = rerr_ff;

  ////////////////////////////////////////////////////////////////////////
  // transmit framer
  always_comb begin
    nxt_tst = tst_ff;
    nxt_tcnt = tcnt_ff;
    nxt_tidx = tidx_ff;
    nxt_tsh = tsh_ff;
    nxt_tpar = tpar_ff;
    nxt_tline = tline_ff;
    if (tst_ff != rlk_pkg::RLK_IDLE) begin
      nxt_tcnt = (tcnt_ff == 16'h0) ? bit_cyc - 16'h1 : tcnt_ff - 16'h1;
    end
    unique case (tst_ff)
      rlk_pkg::RLK_IDLE: if (tx_valid) begin
        nxt_tst = rlk_pkg::RLK_START;
        nxt_tline = 1'b0;
        nxt_tcnt = bit_cyc - 16'h1;
        nxt_tsh = tx_data;
        nxt_tpar = (^tx_data) ^ par_odd;
      end
      rlk_pkg::RLK_START: if (tcnt_ff == 16'h0) begin
        nxt_tst = rlk_pkg::RLK_DATA;
        nxt_tline = tsh_ff[0];
        nxt_tsh = {1'b0, tsh_ff[7:1]};
        nxt_tidx = 3'h0;
      end
      rlk_pkg::RLK_DATA: if (tcnt_ff == 16'h0) begin
        if (tidx_ff == 3'h7) begin
          nxt_tst = par_on ? rlk_pkg::RLK_PAR : rlk_pkg::RLK_STOP;
          nxt_tline = par_on ? tpar_ff : 1'b1;
        end else begin
          nxt_tidx = tidx_ff + 3'h1;
          nxt_tline = tsh_ff[0];
          nxt_tsh = {1'b0, tsh_ff[7:1]};
        end
      end
      rlk_pkg::RLK_PAR: if (tcnt_ff == 16'h0) begin
        nxt_tst = rlk_pkg::RLK_STOP;
        nxt_tline = 1'b1;
      end
      rlk_pkg::RLK_STOP: if (tcnt_ff == 16'h0) begin
        nxt_tst = rlk_pkg::RLK_IDLE;
      end
      default: nxt_tst = rlk_pkg::RLK_IDLE;
    endcase
  end

  // transmit registers, line idles high
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tst_ff <= rlk_pkg::RLK_IDLE;
      tcnt_ff <= 16'h0;
      tidx_ff <= 3'h0;
      tsh_ff <= 8'h00;
      tpar_ff <= 1'b0;
      tline_ff <= 1'b1;
    end else begin
      tst_ff <= nxt_tst;
      tcnt_ff <= nxt_tcnt;
      tidx_ff <= nxt_tidx;
      tsh_ff <= nxt_tsh;
      tpar_ff <= nxt_tpar;
      tline_ff <= nxt_tline;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receive framer, samples mid bit and checks parity and stop
  always_comb begin
    nxt_rst = rst_ff;
    nxt_rcnt = rcnt_ff;
    nxt_ridx = ridx_ff;
    nxt_rsh = rsh_ff;
    nxt_rdata = rdata_ff;
    nxt_rpe = rpe_ff;
    nxt_rval = 1'b0;
    nxt_rerr = 1'b0;
    if (rst_ff != rlk_pkg::RLK_IDLE) begin
      nxt_rcnt = (rcnt_ff == 16'h0) ? bit_cyc - 16'h1 : rcnt_ff - 16'h1;
    end
    unique case (rst_ff)
      rlk_pkg::RLK_IDLE: if (!rx_line) begin
        nxt_rst = rlk_pkg::RLK_START;
        nxt_rcnt = {1'b0, bit_cyc[15:1]};
        nxt_rpe = 1'b0;
      end
      rlk_pkg::RLK_START: if (rcnt_ff == 16'h0) begin
        nxt_rst = rx_line ? rlk_pkg::RLK_IDLE : rlk_pkg::RLK_DATA;
        nxt_ridx = 3'h0;
      end
      rlk_pkg::RLK_DATA: if (rcnt_ff == 16'h0) begin
        nxt_rsh = {rx_line, rsh_ff[7:1]};
        nxt_ridx = ridx_ff + 3'h1;
        if (ridx_ff == 3'h7) begin
          nxt_rst = par_on ? rlk_pkg::RLK_PAR : rlk_pkg::RLK_STOP;
        end
      end
      rlk_pkg::RLK_PAR: if (rcnt_ff == 16'h0) begin
        nxt_rst = rlk_pkg::RLK_STOP;
        nxt_rpe = ((^rsh_ff) ^ rx_line) != par_odd;
      end
      rlk_pkg::RLK_STOP: if (rcnt_ff == 16'h0) begin
        nxt_rst = rlk_pkg::RLK_IDLE;
        if (rx_line && !rpe_ff) begin
          nxt_rdata = rsh_ff;
          nxt_rval = 1'b1;
        end else begin
          nxt_rerr = 1'b1;
        end
      end
      default: nxt_rst = rlk_pkg::RLK_IDLE;
    endcase
  end

  // receive registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_ff <= rlk_pkg::RLK_IDLE;
      rcnt_ff <= 16'h0;
      ridx_ff <= 3'h0;
      rsh_ff <= 8'h00;
      rdata_ff <= 8'h00;
      rpe_ff <= 1'b0;
      rval_ff <= 1'b0;
      rerr_ff <= 1'b0;
    end else begin
      rst_ff <= nxt_rst;
      rcnt_ff <= nxt_rcnt;
      ridx_ff <= nxt_ridx;
      rsh_ff <= nxt_rsh;
      rdata_ff <= nxt_rdata;
      rpe_ff <= nxt_rpe;
      rval_ff <= nxt_rval;
      rerr_ff <= nxt_rerr;
    end
  end

endmodule

// ---- rtl/rlk_link_status.sv ----
// both ends of the remote link: driver status byte and receiver station
// assumes the bench joins drv_ser_out/rcv_ser_in and rcv_ser_out/drv_ser_in
// Summary of operation
// - driver faceplate lamps are status bits 3 to 6, same flops
// - driver local ok follows absence of internal driver fault
// - driver link ok set by good reply, cleared on error or timeout
// - driver remote ok copies receiver reported remote health
// - remote parity error clears bit and stops controller unless run
// - both ends use matching baud and odd, even or no parity
// - receiver local ok drops on link failure or block mismatch
// - receiver link ok set by valid frame, cleared on failure
// - receiver remote ok drops on illegal block, loose cable, supply
// - receiver parity ok drops on station parity error
// - receiver deserializes outputs, serializes inputs, checks frames
// - halt on failures by default; receiver clears outputs on failure unless rcv_hold_outputs is set
// - heartbeat toggles per good scan, frozen if bits 3-6 not all one
// - transfer bit toggles with each new input byte
module rlk_link_status #(
  parameter int BIT_CYC = rlk_pkg::DEF_BIT_CYC,
  parameter int REPLY_TMO_CYC = rlk_pkg::REPLY_TMO_CYC,
  parameter int RCV_TMO_CYC = rlk_pkg::RCV_TMO_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // driver options
  input wire logic [1:0] drv_par_mode,
  input wire logic drv_baud_user,
  input wire logic [15:0] drv_user_bit_cyc,
  input wire logic drv_run_on_comm,
  input wire logic drv_run_on_par,
  input wire logic [2:0] drv_block,
  // driver controller side
  input wire logic drv_scan,
  input wire logic [7:0] drv_out_data,
  input wire logic drv_fault,
  output logic [7:0] drv_in_data,
  output logic [7:0] drv_status,
  output logic [3:0] drv_led,
  output logic drv_halt,
  // driver serial line
  input wire logic drv_ser_in,
  output logic drv_ser_out,
  // receiver options
  input wire logic [1:0] rcv_par_mode,
  input wire logic rcv_baud_user,
  input wire logic [15:0] rcv_user_bit_cyc,
  input wire logic rcv_hold_outputs,
  input wire logic [2:0] rcv_block,
  input wire logic rcv_big_block,
  // receiver station side
  input wire logic [7:0] rcv_in_data,
  input wire logic rcv_bp_perr,
  input wire logic rcv_loose_conn,
  input wire logic rcv_supply_fail,
  output logic [7:0] rcv_out_data,
  output logic [3:0] rcv_led,
  // receiver serial line
  input wire logic rcv_ser_in,
  output logic rcv_ser_out
);

  rlk_pkg::rlk_drv_t dst_ff, nxt_dst;
  rlk_pkg::rlk_rcv_t rst_ff, nxt_rst;
  logic [23:0] dtmo_ff, nxt_dtmo, rtmo_ff, nxt_rtmo;
  logic [7:0] dst_b0_ff, nxt_dst_b0, din_ff, nxt_din, dstat_ff, nxt_dstat;
  logic [7:0] rb0_ff, nxt_rb0, rout_ff, nxt_rout, rin_ff, nxt_rin;
  logic [3:0] rled_ff, nxt_rled;
  logic dridx_ff, nxt_dridx, dhalt_ff, nxt_dhalt;
  logic rlink_ff, nxt_rlink, rmis_ff, nxt_rmis, rperr_ff, nxt_rperr;
  logic [7:0] d_txd, r_txd, d_rxd, r_rxd;
  logic d_txv, d_txr, d_rxv, d_rxe, r_txv, r_txr, r_rxv, r_rxe;
  logic r_fail, r_good, r_match, r_rem_ok;
  logic [15:0] d_bit, r_bit;

  assign drv_in_data = din_ff;
  assign drv_status = dstat_ff;
  assign drv_led = dstat_ff[rlk_pkg::ST_LOCAL:rlk_pkg::ST_RPAR];
  assign drv_halt = dhalt_ff;
  assign rcv_out_data = rout_ff;
  assign rcv_led = rled_ff;

  // per end baud selection, documented rate unless user rate chosen
  assign d_bit = drv_baud_user ? drv_user_bit_cyc : 16'(BIT_CYC);
  assign r_bit = rcv_baud_user ? rcv_user_bit_cyc : 16'(BIT_CYC);

  ////////////////////////////////////////////////////////////////////////
  // driver end framer
  rlk_serial u_drv_ser (
    .clk(clk), .rstn(rstn), .bit_cyc(d_bit), .par_mode(drv_par_mode),
    .tx_data(d_txd), .tx_valid(d_txv), .tx_ready(d_txr),
    .tx_line(drv_ser_out), .rx_line(drv_ser_in), .rx_data(d_rxd),
    .rx_valid(d_rxv), .rx_err(d_rxe)
  );

  // driver scan: send block and outputs, collect inputs and status
  always_comb begin
    nxt_dst = dst_ff;
    nxt_dtmo = dtmo_ff;
    nxt_dst_b0 = dst_b0_ff;
    nxt_dridx = dridx_ff;
    nxt_din = din_ff;
    nxt_dstat = dstat_ff;
    d_txv = 1'b0;
    d_txd = {5'h00, drv_block};
    unique case (dst_ff)
      rlk_pkg::RLK_D_IDLE: if (drv_scan) nxt_dst = rlk_pkg::RLK_D_TX0;
      rlk_pkg::RLK_D_TX0: begin
        d_txv = 1'b1;
        if (d_txr) nxt_dst = rlk_pkg::RLK_D_TX1;
      end
      rlk_pkg::RLK_D_TX1: begin
        d_txv = 1'b1;
        d_txd = drv_out_data;
        nxt_dtmo = 24'h0;
        nxt_dridx = 1'b0;
        if (d_txr) nxt_dst = rlk_pkg::RLK_D_WAIT;
      end
      rlk_pkg::RLK_D_WAIT: begin
        nxt_dtmo = dtmo_ff + 24'h1;
        if (d_rxe || dtmo_ff == 24'(REPLY_TMO_CYC - 1)) begin
          nxt_dstat[rlk_pkg::ST_LINK] = 1'b0;
          nxt_dst = rlk_pkg::RLK_D_IDLE;
        end else if (d_rxv && !dridx_ff) begin
          nxt_dst_b0 = d_rxd;
          nxt_dridx = 1'b1;
        end else if (d_rxv) begin
          nxt_din = dst_b0_ff;
          nxt_dstat[rlk_pkg::ST_XFER] = ~dstat_ff[rlk_pkg::ST_XFER];
          nxt_dstat[rlk_pkg::ST_LINK] = 1'b1;
          nxt_dstat[rlk_pkg::ST_ROK] = d_rxd[rlk_pkg::RS_ROK];
          nxt_dstat[rlk_pkg::ST_RPAR] = d_rxd[rlk_pkg::RS_RPAR];
          nxt_dst = rlk_pkg::RLK_D_IDLE;
        end
      end
    endcase
    nxt_dstat[rlk_pkg::ST_LOCAL] = !drv_fault;
    if (nxt_dst == rlk_pkg::RLK_D_IDLE && dst_ff == rlk_pkg::RLK_D_WAIT &&
        nxt_dstat[rlk_pkg::ST_LOCAL:rlk_pkg::ST_RPAR] == 4'hF) begin
      nxt_dstat[rlk_pkg::ST_BEAT] = ~dstat_ff[rlk_pkg::ST_BEAT];
    end
    // halt request from the flags as they stand
    nxt_dhalt = (!dstat_ff[rlk_pkg::ST_LINK] && !drv_run_on_comm) ||
                (!dstat_ff[rlk_pkg::ST_RPAR] && !drv_run_on_par);
  end

  // driver registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dst_ff <= rlk_pkg::RLK_D_IDLE;
      dtmo_ff <= 24'h0;
      dst_b0_ff <= 8'h00;
      dridx_ff <= 1'b0;
      din_ff <= 8'h00;
      dstat_ff <= rlk_pkg::ST_RST;
      dhalt_ff <= 1'b0;
    end else begin
      dst_ff <= nxt_dst;
      dtmo_ff <= nxt_dtmo;
      dst_b0_ff <= nxt_dst_b0;
      dridx_ff <= nxt_dridx;
      din_ff <= nxt_din;
      dstat_ff <= nxt_dstat;
      dhalt_ff <= nxt_dhalt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receiver end framer
  rlk_serial u_rcv_ser (
    .clk(clk), .rstn(rstn), .bit_cyc(r_bit), .par_mode(rcv_par_mode),
    .tx_data(r_txd), .tx_valid(r_txv), .tx_ready(r_txr),
    .tx_line(rcv_ser_out), .rx_line(rcv_ser_in), .rx_data(r_rxd),
    .rx_valid(r_rxv), .rx_err(r_rxe)
  );

  // receiver failure, match and health terms
  assign r_fail = r_rxe || (rtmo_ff == 24'(RCV_TMO_CYC - 1));
  assign r_good = r_rxv && !r_fail && rst_ff == rlk_pkg::RLK_R_RX1;
  assign r_match = (rb0_ff == {5'h00, rcv_block});
  assign r_rem_ok = !(rcv_big_block && rcv_block[2]) &&
                    !rcv_loose_conn && !rcv_supply_fail;

  // receiver frame handling and station outputs
  always_comb begin
    nxt_rst = rst_ff;
    nxt_rb0 = rb0_ff;
    nxt_rout = rout_ff;
    nxt_rin = rin_ff;
    nxt_rlink = rlink_ff;
    nxt_rmis = rmis_ff;
    nxt_rtmo = (r_rxv || r_fail) ? 24'h0 : rtmo_ff + 24'h1;
    r_txv = 1'b0;
    r_txd = rin_ff;
    unique case (rst_ff)
      rlk_pkg::RLK_R_RX0: if (r_rxv && !r_fail) begin
        nxt_rb0 = r_rxd;
        nxt_rst = rlk_pkg::RLK_R_RX1;
      end
      rlk_pkg::RLK_R_RX1: if (r_good) begin
        nxt_rlink = 1'b1;
        nxt_rmis = !r_match;
        if (r_match) nxt_rout = r_rxd;
        nxt_rin = rcv_in_data;
        nxt_rst = rlk_pkg::RLK_R_TX0;
      end
      rlk_pkg::RLK_R_TX0: begin
        r_txv = 1'b1;
        if (r_txr) nxt_rst = rlk_pkg::RLK_R_TX1;
      end
      rlk_pkg::RLK_R_TX1: begin
        r_txv = 1'b1;
        r_txd = {6'h00, r_rem_ok, !rperr_ff};
        if (r_txr) nxt_rst = rlk_pkg::RLK_R_RX0;
      end
    endcase
    if (r_fail) begin
      nxt_rlink = 1'b0;
      if (rst_ff == rlk_pkg::RLK_R_RX1) nxt_rst = rlk_pkg::RLK_R_RX0;
      if (!rcv_hold_outputs) nxt_rout = 8'h00;
    end
    // station parity error wins over the clear by a good frame
    nxt_rperr = rcv_bp_perr || (rperr_ff && !r_good);
    nxt_rled = {nxt_rlink && !nxt_rmis, nxt_rlink, r_rem_ok, !nxt_rperr};
  end

  // receiver registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_ff <= rlk_pkg::RLK_R_RX0;
      rtmo_ff <= 24'h0;
      rb0_ff <= 8'h00;
      rout_ff <= 8'h00;
      rin_ff <= 8'h00;
      rlink_ff <= 1'b0;
      rmis_ff <= 1'b0;
      rperr_ff <= 1'b0;
      rled_ff <= 4'h0;
    end else begin
      rst_ff <= nxt_rst;
      rtmo_ff <= nxt_rtmo;
      rb0_ff <= nxt_rb0;
      rout_ff <= nxt_rout;
      rin_ff <= nxt_rin;
      rlink_ff <= nxt_rlink;
      rmis_ff <= nxt_rmis;
      rperr_ff <= nxt_rperr;
      rled_ff <= nxt_rled;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_local_fault: assert property (@(posedge clk) disable iff (!rstn)
    $rose(drv_fault) |=> !drv_led[3]) else $error("local ok kept on fault");
  a_link_err: assert property (@(posedge clk) disable iff (!rstn)
    (dst_ff == rlk_pkg::RLK_D_WAIT && d_rxe) |=>
    !drv_led[2] && dst_ff == rlk_pkg::RLK_D_IDLE)
    else $error("link ok kept after reply error");
  a_remote_copy: assert property (@(posedge clk) disable iff (!rstn)
    (dst_ff == rlk_pkg::RLK_D_WAIT && d_rxv && dridx_ff && !d_rxe &&
     dtmo_ff != 24'(REPLY_TMO_CYC - 1))
    |=> drv_led[1] == $past(d_rxd[1])) else $error("remote ok not copied");
  a_par_halt: assert property (@(posedge clk) disable iff (!rstn)
    (!drv_led[0] && !drv_run_on_par) |=> drv_halt)
    else $error("no halt on remote parity error");
  a_beat_freeze: assert property (@(posedge clk) disable iff (!rstn)
    $changed(drv_status[7]) |-> drv_led == 4'hF)
    else $error("heartbeat moved with a bad status bit");
  a_xfer_toggle: assert property (@(posedge clk) disable iff (!rstn)
    $changed(drv_status[0]) |-> $past(dst_ff) == rlk_pkg::RLK_D_WAIT &&
    dst_ff == rlk_pkg::RLK_D_IDLE) else $error("transfer bit out of scan");
  a_outs_off: assert property (@(posedge clk) disable iff (!rstn)
    (r_fail && !rcv_hold_outputs) |=> rcv_out_data == 8'h00)
    else $error("outputs not cleared on link failure");
  a_rcv_link: assert property (@(posedge clk) disable iff (!rstn)
    r_fail |=> !rcv_led[3] && !rcv_led[2]) else $error("receiver ok kept");
  a_rcv_par: assert property (@(posedge clk) disable iff (!rstn)
    rcv_bp_perr |=> !rcv_led[0]) else $error("parity ok kept on error");
  a_rcv_remote: assert property (@(posedge clk) disable iff (!rstn)
    (rcv_loose_conn || rcv_supply_fail) |=> !rcv_led[1])
    else $error("remote ok kept on station fault");
  a_rcv_deser: assert property (@(posedge clk) disable iff (!rstn)
    (r_good && r_match) |=> rcv_out_data == $past(r_rxd) ##1 r_txv)
    else $error("output byte not delivered");

endmodule

// ---- bench/rlk_line_model.sv ----
// serial cable model joining the driver and receiver line ends
// assumes both ends idle high; cut stands for a removed cable
module rlk_line_model (
  // line ends
  input wire logic drv_tx,
  input wire logic rcv_tx,
  output logic drv_rx,
  output logic rcv_rx,
  // fault control
  input wire logic cut
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////
  // line pull-up wins while the cable is cut
  assign rcv_rx = cut ? 1'h1 : drv_tx;
  assign drv_rx = cut ? 1'h1 : rcv_tx;
endmodule

// ---- bench/tb.sv ----
// self-checking bench for the remote link status block
// assumes shortened bit time and timeouts set through parameters
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, drv_baud_user, drv_run_on_comm, drv_run_on_par;
  logic drv_scan, drv_fault, drv_halt, drv_ser_in, drv_ser_out, cut;
  logic rcv_baud_user, rcv_hold_outputs, rcv_big_block, rcv_bp_perr;
  logic rcv_loose_conn, rcv_supply_fail, rcv_ser_in, rcv_ser_out;
  logic [1:0] drv_par_mode, rcv_par_mode, pm;
  logic [15:0] drv_user_bit_cyc, rcv_user_bit_cyc;
  logic [2:0] drv_block, rcv_block;
  logic [7:0] drv_out_data, drv_in_data, drv_status;
  logic [7:0] rcv_in_data, rcv_out_data, last_out;
  logic [3:0] drv_led, rcv_led;
  logic xf, hb;
  int err_count, samples_checked, cycles, w;
  ////////////////////////////////////////////////////////////////////////
  // design and cable
  rlk_link_status #(.BIT_CYC(8), .REPLY_TMO_CYC(400), .RCV_TMO_CYC(2000))
  rlk_link_status_inst (
    .clk, .rstn, .drv_par_mode, .drv_baud_user, .drv_user_bit_cyc,
    .drv_run_on_comm, .drv_run_on_par, .drv_block, .drv_scan,
    .drv_out_data, .drv_fault, .drv_in_data, .drv_status, .drv_led,
    .drv_halt, .drv_ser_in, .drv_ser_out, .rcv_par_mode, .rcv_baud_user,
    .rcv_user_bit_cyc, .rcv_hold_outputs, .rcv_block, .rcv_big_block,
    .rcv_in_data, .rcv_bp_perr, .rcv_loose_conn, .rcv_supply_fail,
    .rcv_out_data, .rcv_led, .rcv_ser_in, .rcv_ser_out
  );
  rlk_line_model rlk_line_model_inst (
    .drv_tx(drv_ser_out), .rcv_tx(rcv_ser_out), .drv_rx(drv_ser_in),
    .rcv_rx(rcv_ser_in), .cut(cut)
  );
  ////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial clk = 1'h0;
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // wait whole cycles, then settle past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one scan, ended by the transfer toggle or a bounded wait
  task automatic scan();
    logic b;
    int k;
    b = drv_status[0];
    drv_scan <= 1'h1;
    cyc(1);
    drv_scan <= 1'h0;
    k = 0;
    while (drv_status[0] === b && k < 700) begin
      cyc(1);
      k++;
    end
    cyc(3);
  endtask
  // good scan carrying one byte each way
  task automatic xfer(input logic [7:0] o, i);
    drv_out_data <= o;
    rcv_in_data <= i;
    scan();
    chk("rcv_out_data", rcv_out_data, o);
    chk("drv_in_data", drv_in_data, i);
    last_out = o;
  endtask
  // status byte after an answered scan, nibble is bits 6 to 3
  task automatic post(input logic [3:0] nib);
    xf = ~xf;
    if (nib === 4'hF) hb = ~hb;
    chk("drv_status", drv_status, {hb, nib, 2'h0, xf});
    chk("drv_led", 8'(drv_led), 8'(nib));
  endtask
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {rstn, drv_baud_user, drv_run_on_comm, drv_run_on_par} = 4'h0;
    {drv_scan, drv_fault, rcv_baud_user, rcv_hold_outputs} = 4'h0;
    {rcv_big_block, rcv_bp_perr, rcv_loose_conn, rcv_supply_fail} = 4'h0;
    cut = 1'h0;
    drv_par_mode = rlk_pkg::PAR_ODD;
    rcv_par_mode = rlk_pkg::PAR_ODD;
    drv_user_bit_cyc = 16'h0006;
    rcv_user_bit_cyc = 16'h0006;
    drv_block = 3'h0;
    rcv_block = 3'h0;
    drv_out_data = 8'h00;
    rcv_in_data = 8'h00;
    {xf, hb} = 2'h0;
    err_count = 0;
    samples_checked = 0;
    cycles = 0;
    cyc(5);
    chk("drv_status", drv_status, rlk_pkg::ST_RST);
    chk("idle", 8'({drv_halt, drv_ser_out, rcv_ser_out}), 8'h03);
    rstn = 1'h1;
    cyc(2);
    chk("rcv link", 8'(rcv_led[2]), 8'h00);
    chk("halt", 8'(drv_halt), 8'h01);
    chk("local", 8'(drv_status[6]), 8'h01);
    // default link, then every parity mode and the user rate
    xfer(8'hA5, 8'h3C);
    post(4'hF);
    chk("rcv_led", 8'(rcv_led), 8'h0F);
    chk("halt", 8'(drv_halt), 8'h00);
    for (int i = 0; i < 4; i++) begin
      pm = (i == 3) ? rlk_pkg::PAR_ODD : 2'(i);
      drv_par_mode <= pm;
      rcv_par_mode <= pm;
      drv_baud_user <= (i == 3);
      rcv_baud_user <= (i == 3);
      cyc(2);
      xfer(8'(8'h5A + i), 8'(8'hC3 - i));
      post(4'hF);
    end
    // station parity error, stop then run option
    rcv_bp_perr <= 1'h1;
    cyc(2);
    chk("rcv parity", 8'(rcv_led[0]), 8'h00);
    scan();
    post(4'hE);
    chk("halt", 8'(drv_halt), 8'h01);
    drv_run_on_par <= 1'h1;
    cyc(2);
    chk("halt", 8'(drv_halt), 8'h00);
    rcv_bp_perr <= 1'h0;
    drv_run_on_par <= 1'h0;
    xfer(8'h96, 8'h69);
    post(4'hF);
    chk("rcv_led", 8'(rcv_led), 8'h0F);
    // remote faults: supply, loose cable, illegal block
    for (int j = 0; j < 3; j++) begin
      rcv_supply_fail <= (j == 0);
      rcv_loose_conn <= (j == 1);
      rcv_big_block <= (j == 2);
      drv_block <= (j == 2) ? 3'h4 : 3'h0;
      rcv_block <= (j == 2) ? 3'h4 : 3'h0;
      cyc(2);
      chk("rcv remote", 8'(rcv_led[1]), 8'h00);
      scan();
      post(4'hD);
      {rcv_supply_fail, rcv_loose_conn, rcv_big_block} <= 3'h0;
      {drv_block, rcv_block} <= 6'h00;
      cyc(2);
    end
    // block mismatch is answered but outputs stay
    drv_block <= 3'h1;
    drv_out_data <= 8'h77;
    scan();
    chk("rcv local", 8'(rcv_led[3]), 8'h00);
    chk("rcv_out_data", rcv_out_data, last_out);
    post(4'hF);
    drv_block <= 3'h0;
    // internal driver fault
    drv_fault <= 1'h1;
    cyc(2);
    chk("local", 8'({drv_status[6], drv_led[3]}), 8'h00);
    drv_fault <= 1'h0;
    cyc(2);
    // cable cut, halt then run option, receiver clears outputs
    cut <= 1'h1;
    scan();
    chk("link", 8'(drv_status[5]), 8'h00);
    chk("halt", 8'(drv_halt), 8'h01);
    drv_run_on_comm <= 1'h1;
    cyc(2);
    chk("halt", 8'(drv_halt), 8'h00);
    cyc(2100);
    chk("rcv_led", 8'(rcv_led[3:2]), 8'h00);
    chk("rcv_out_data", rcv_out_data, 8'h00);
    cut <= 1'h0;
    drv_run_on_comm <= 1'h0;
    xfer(8'hE1, 8'h1E);
    post(4'hF);
    chk("rcv_led", 8'(rcv_led), 8'h0F);
    // reply parity error: driver drops link without a transfer toggle
    drv_out_data <= 8'h3A;
    drv_scan <= 1'h1;
    cyc(1);
    drv_scan <= 1'h0;
    w = 0;
    while (rcv_out_data !== 8'h3A && w < 400) begin
      cyc(1);
      w++;
    end
    drv_par_mode <= rlk_pkg::PAR_EVEN;
    cyc(400);
    chk("xfer", 8'(drv_status[0]), 8'(xf));
    chk("link", 8'({drv_status[5], drv_halt}), 8'h01);
    drv_par_mode <= rlk_pkg::PAR_ODD;
    last_out = 8'h3A;
    // hold option keeps outputs through a failure
    rcv_hold_outputs <= 1'h1;
    cut <= 1'h1;
    cyc(2800);
    chk("rcv link", 8'(rcv_led[2]), 8'h00);
    chk("rcv_out_data", rcv_out_data, last_out);
    report_and_stop();
  end
endmodule
